// ===== pkg/pid_position_pkg.sv
// Constants, scaling factors and register map of the closed-loop position regulator.
// Assumes a single 20 MHz core clock and a plain strobe-based register port.
package pid_position_pkg;

	// Core clock and control period.
	localparam int CLK_PERIOD_NS = 50;
	localparam int CTRL_PERIOD_NS = 100000;
	localparam int CTRL_PERIOD_CYC = CTRL_PERIOD_NS / CLK_PERIOD_NS;
	localparam int TICK_W = 12;

	// Gain scaling: full duty at 256 rev error, 52.5 rev*s integral, 96000 rpm speed error.
	localparam int P_FULL_REVS = 256;
	localparam int I_FULL_REV_S_X10 = 525;
	localparam int D_FULL_RPM = 96000;
	localparam int FRAC_SH = 24;
	localparam int DUTY_SH = 15;
	localparam int DEN_SH = FRAC_SH - DUTY_SH;
	localparam logic signed [63:0] P_MUL = 64'(longint'(1) <<< FRAC_SH) / P_FULL_REVS;
	localparam logic signed [63:0] I_MUL = 64'((longint'(1) <<< FRAC_SH) * CTRL_PERIOD_NS * 10
		/ (longint'(I_FULL_REV_S_X10) * 1000000000));
	localparam logic signed [63:0] D_MUL = 64'((longint'(1) <<< FRAC_SH) * 60 * 1000000000
		/ (longint'(D_FULL_RPM) * CTRL_PERIOD_NS));

	// Internal widths of the regulator arithmetic.
	localparam int ERR_W = 24;
	localparam int DERR_W = 16;
	localparam int INT_W = 32;
	localparam int NUM_W = 80;
	localparam int DEN_W = 41;

	// Register byte offsets.
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_KP = 8'h04;
	localparam logic [7:0] REG_KI = 8'h08;
	localparam logic [7:0] REG_KD = 8'h0C;
	localparam logic [7:0] REG_UNOM = 8'h10;
	localparam logic [7:0] REG_IPS = 8'h14;
	localparam logic [7:0] REG_SPEED = 8'h18;
	localparam logic [7:0] REG_DECEL = 8'h1C;
	localparam logic [7:0] REG_TARGET = 8'h20;
	localparam logic [7:0] REG_CMD = 8'h24;
	localparam logic [7:0] REG_STATUS = 8'h28;
	localparam logic [7:0] REG_MEAS = 8'h2C;
	localparam logic [7:0] REG_RUNPOS = 8'h30;
	localparam logic [7:0] REG_OUT = 8'h34;

	// Field positions.
	localparam int CTRL_BLDC_BIT = 0;
	localparam int CTRL_ACCEL_BIT = 1;
	localparam int CTRL_HALT_LEFT_BIT = 2;
	localparam int CTRL_HALT_RIGHT_BIT = 3;
	localparam int CMD_MOVE_BIT = 0;
	localparam int CMD_STOP_BIT = 1;
	localparam int CMD_SMOOTH_HALT_BIT = 2;

	// Values after reset, and the largest duty magnitude.
	localparam logic [3:0] CTRL_RST = 4'h0;
	localparam logic [15:0] GAIN_RST = 16'h0000;
	localparam logic [15:0] UNOM_RST = 16'h0100;
	localparam logic [15:0] IPS_RST = 16'h0100;
	localparam logic [31:0] SPEED_RST = 32'h0000_0000;
	localparam logic [31:0] DECEL_RST = 32'h0000_0001;
	localparam logic [15:0] DUTY_MAX = 16'h7FFF;

	// Regulator sequencer states.
	typedef enum logic [1:0] {ST_IDLE, ST_CALC, ST_DIV, ST_APPLY} reg_state_t;

endpackage

// ===== rtl/pid_norm_divider.sv
// Restoring divider that normalises the control action into a saturated duty magnitude.
// Assumes start pulses only while idle; den of zero saturates the result.
`timescale 1ns/100ps
module pid_norm_divider #(
	parameter int N_W = 80,
	parameter int D_W = 41,
	parameter int Q_W = 15
) (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic srst,
	// Request.
	input wire logic start,
	input wire logic [N_W-1:0] num,
	input wire logic [D_W-1:0] den,
	// Answer.
	output logic done,
	output logic [Q_W-1:0] quot
);
	localparam int CNT_W = $clog2(N_W + 1);

	if (N_W <= Q_W || D_W < 2) begin : g_chk
		$error("pid_norm_divider: widths cannot be served");
	end

	typedef struct packed {
		logic busy;
		logic [CNT_W-1:0] cnt;
		logic [D_W-1:0] rem;
		logic [D_W-1:0] den;
		logic [N_W-1:0] quo;
		logic done;
		logic [Q_W-1:0] quot;
	} div_state_t;

	div_state_t st_reg;
	div_state_t st_next;
	logic [D_W:0] r_sh;

	////////////////////////////////////////////////////////////////////////////////
	// One quotient bit per clock; the result saturates to the largest magnitude.
	always_comb begin
		st_next = st_reg;
		st_next.done = 1'b0;
		r_sh = {st_reg.rem, st_reg.quo[N_W-1]};
		if (start && !st_reg.busy) begin
			st_next.busy = 1'b1;
			st_next.cnt = CNT_W'(N_W);
			st_next.rem = '0;
			st_next.den = den;
			st_next.quo = num;
		end else if (st_reg.busy) begin
			if (r_sh >= {1'b0, st_reg.den}) begin
				st_next.rem = D_W'(r_sh - {1'b0, st_reg.den});
				st_next.quo = {st_reg.quo[N_W-2:0], 1'b1};
			end else begin
				st_next.rem = r_sh[D_W-1:0];
				st_next.quo = {st_reg.quo[N_W-2:0], 1'b0};
			end
			st_next.cnt = st_reg.cnt - 1'b1;
			if (st_reg.cnt == CNT_W'(1)) begin
				st_next.busy = 1'b0;
				st_next.done = 1'b1;
			end
		end
		// Divide by zero or an oversized quotient clamps to full scale.
		if (st_reg.done && (st_reg.den == '0 || |st_reg.quo[N_W-1:Q_W])) begin
			st_next.quot = '1;
		end else if (st_reg.done) begin
			st_next.quot = st_reg.quo[Q_W-1:0];
		end
	end

	// State register.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign done = st_reg.done;
	assign quot = st_reg.quot;

	property p_div_busy;
		@(posedge core_clk) disable iff (srst) (start && !st_reg.busy) |=> st_reg.busy ##[1:90] st_reg.done;
	endproperty
	a_div_busy: assert property (p_div_busy) else $error("divider did not finish");
endmodule

// ===== rtl/pid_position_regulator.sv
// Closed-loop position regulator: running target, PID law, duty or current output.
// Assumes encoder and limit pins are asynchronous and supply_level is on core_clk.
//
// Operation
// - Shaft position is regulated in closed loop by a PID on coordinate.
// - Running target advances per period from speed, target and commands.
// - Error is running target minus encoder-measured coordinate.
// - Action is Kp times error plus Ki integral plus Kd rate.
// - DC duty equals action times nominal over supply times counts per rev.
// - Each gain is an unsigned 16-bit integer with internal scaling.
// - Kp of one gives full duty at 256 revolutions of lead.
// - Ki of one gives full duty at 52.5 revolution-seconds integral.
// - Kd of one gives full duty at 96000 rpm speed excess.
// - Move is finished once the shaft reaches target, despite later oscillation.
// - Immediate halt stops the shaft at once without any ramp.
// - Enabled limit switch halts immediately when reached, never ramped.
// - Smooth halt with acceleration mode ramps speed down by deceleration.
// - Smooth halt without acceleration mode acts as immediate halt.
// - For BLDC the same law commands winding current instead of duty.
// - Gain effects and scaling are identical for BLDC and DC.
// - Nominal voltage comes from the maximum winding voltage setting.
//
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/100ps
module pid_position_regulator
	import pid_position_pkg::*;
(
	// Clock and reset.
	input wire logic core_clk,
	input wire logic srst,
	// Register port.
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Supply measurement and motor feedback pins.
	input wire logic [15:0] supply_level,
	input wire logic enc_a,
	input wire logic enc_b,
	input wire logic limit_left,
	input wire logic limit_right,
	// Drive outputs and status.
	output logic [15:0] pwm_fill_factor,
	output logic [15:0] current_cmd,
	output logic move_done
);
	typedef struct packed {
		logic [3:0] ctrl;
		logic [15:0] kp;
		logic [15:0] ki;
		logic [15:0] kd;
		logic [15:0] unom;
		logic [15:0] encoder_counts_per_rev;
		logic [31:0] speed;
		logic [31:0] decel;
		logic signed [31:0] target;
		logic signed [31:0] run_pos;
		logic signed [31:0] vel;
		logic moving;
		logic halting;
		logic done;
		logic signed [31:0] meas_pos;
		logic [2:0] enc_a_sync;
		logic [2:0] enc_b_sync;
		logic [1:0] lim_l_sync;
		logic [1:0] lim_r_sync;
		logic [TICK_W-1:0] tick_cnt;
		reg_state_t fsm;
		logic signed [ERR_W-1:0] err_prev;
		logic signed [INT_W-1:0] integ;
		logic neg;
		logic div_start;
		logic [NUM_W-1:0] div_num;
		logic [DEN_W-1:0] div_den;
		logic signed [15:0] pwm;
		logic signed [15:0] cur;
		logic [31:0] rdata;
	} reg_state_s_t;

	reg_state_s_t st_reg;
	reg_state_s_t st_next;
	logic div_done;
	logic [DUTY_SH-1:0] div_quot;
	logic signed [63:0] err_full;
	logic signed [ERR_W-1:0] err;
	logic signed [DERR_W-1:0] derr;
	logic signed [INT_W-1:0] integ_new;
	logic signed [63:0] p_term;
	logic signed [63:0] i_term;
	logic signed [63:0] d_term;
	logic signed [63:0] u_sum;
	logic [63:0] u_abs;
	logic signed [15:0] duty;
	logic tick;
	logic wr_cmd;

	// Saturating clamp of a signed value into the w-bit range -2^(w-1) to 2^(w-1)-1.
	function automatic logic signed [63:0] clamp(input logic signed [63:0] v, input int w);
		logic signed [63:0] lim;
		lim = 64'sd1 <<< (w - 1);
		if (v >= lim) begin
			return lim - 64'sd1;
		end else if (v < -lim) begin
			return -lim;
		end
		return v;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Normalisation divider; it fits well inside one control period.
	pid_norm_divider #(
		.N_W(NUM_W),
		.D_W(DEN_W),
		.Q_W(DUTY_SH)
	) u_div (
		.core_clk(core_clk),
		.srst(srst),
		.start(st_reg.div_start),
		.num(st_reg.div_num),
		.den(st_reg.div_den),
		.done(div_done),
		.quot(div_quot)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Regulator arithmetic on the registered running and measured coordinates.
	always_comb begin
		err_full = 64'(st_reg.run_pos) - 64'(st_reg.meas_pos);
		err = ERR_W'(clamp(err_full, ERR_W));
		derr = DERR_W'(clamp(64'(err) - 64'(st_reg.err_prev), DERR_W));
		integ_new = INT_W'(clamp(64'(st_reg.integ) + 64'(err), INT_W));
		// Unsigned gains scaled to a common Q24 action; same path for both motor types.
		p_term = $signed({1'b0, st_reg.kp}) * err * P_MUL;
		i_term = $signed({1'b0, st_reg.ki}) * integ_new * I_MUL;
		d_term = $signed({1'b0, st_reg.kd}) * derr * D_MUL;
		u_sum = p_term + i_term + d_term;
		u_abs = u_sum[63] ? 64'(-u_sum) : 64'(u_sum);
		duty = st_reg.neg ? -$signed({1'b0, div_quot}) : $signed({1'b0, div_quot});
		tick = st_reg.tick_cnt == TICK_W'(CTRL_PERIOD_CYC - 1);
		wr_cmd = reg_wr && reg_addr == REG_CMD;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Next state: pins, registers, trajectory, halts and the regulator sequence.
	always_comb begin
		st_next = st_reg;
		st_next.div_start = 1'b0;
		// Two-flop synchronisers; only stage 1 and later feed logic.
		st_next.enc_a_sync = {st_reg.enc_a_sync[1:0], enc_a};
		st_next.enc_b_sync = {st_reg.enc_b_sync[1:0], enc_b};
		st_next.lim_l_sync = {st_reg.lim_l_sync[0], limit_left};
		st_next.lim_r_sync = {st_reg.lim_r_sync[0], limit_right};
		// Quadrature decode; a double transition is ignored as invalid.
		if ((st_reg.enc_a_sync[1] ^ st_reg.enc_a_sync[2]) != (st_reg.enc_b_sync[1] ^ st_reg.enc_b_sync[2])) begin
			if (st_reg.enc_a_sync[2] ^ st_reg.enc_b_sync[1]) begin
				st_next.meas_pos = st_reg.meas_pos + 32'sd1;
			end else begin
				st_next.meas_pos = st_reg.meas_pos - 32'sd1;
			end
		end
		st_next.tick_cnt = tick ? '0 : st_reg.tick_cnt + 1'b1;

		// Trajectory step once per period.
		if (tick && st_reg.moving) begin
			if (st_reg.halting) begin
				// Speed magnitude falls by the deceleration each period.
				if (st_reg.vel >= 0 && 32'(st_reg.vel) > st_reg.decel) begin
					st_next.vel = st_reg.vel - $signed(st_reg.decel);
				end else if (st_reg.vel < 0 && 32'(-st_reg.vel) > st_reg.decel) begin
					st_next.vel = st_reg.vel + $signed(st_reg.decel);
				end else begin
					st_next.vel = '0;
					st_next.moving = 1'b0;
					st_next.halting = 1'b0;
				end
				st_next.run_pos = st_reg.run_pos + st_reg.vel;
			end else if ((st_reg.vel >= 0 && st_reg.run_pos + st_reg.vel >= st_reg.target)
				|| (st_reg.vel < 0 && st_reg.run_pos + st_reg.vel <= st_reg.target)) begin
				st_next.run_pos = st_reg.target;
				st_next.vel = '0;
				st_next.moving = 1'b0;
			end else begin
				st_next.run_pos = st_reg.run_pos + st_reg.vel;
			end
		end
		// Finished once the shaft meets the settled target; later swings do not clear it.
		if (!st_reg.moving && st_reg.meas_pos == st_reg.run_pos) begin
			st_next.done = 1'b1;
		end

		// Limit switch halts are always immediate.
		if ((st_reg.ctrl[CTRL_HALT_LEFT_BIT] && st_reg.lim_l_sync[1] && st_reg.vel < 0)
			|| (st_reg.ctrl[CTRL_HALT_RIGHT_BIT] && st_reg.lim_r_sync[1] && st_reg.vel > 0)) begin
			st_next.vel = '0;
			st_next.moving = 1'b0;
			st_next.halting = 1'b0;
			st_next.run_pos = st_reg.meas_pos;
		end

		// Register writes; halt commands take priority over a move in the same word.
		if (reg_wr) begin
			case (reg_addr)
				REG_CTRL: st_next.ctrl = reg_wdata[3:0];
				REG_KP: st_next.kp = reg_wdata[15:0];
				REG_KI: st_next.ki = reg_wdata[15:0];
				REG_KD: st_next.kd = reg_wdata[15:0];
				REG_UNOM: st_next.unom = reg_wdata[15:0];
				REG_IPS: st_next.encoder_counts_per_rev = reg_wdata[15:0];
				REG_SPEED: st_next.speed = reg_wdata;
				REG_DECEL: st_next.decel = reg_wdata;
				REG_TARGET: st_next.target = reg_wdata;
				default: st_next.ctrl = st_next.ctrl;
			endcase
		end
		if (wr_cmd && reg_wdata[CMD_MOVE_BIT]) begin
			st_next.vel = (st_reg.target >= st_reg.run_pos) ? $signed(st_reg.speed) : -$signed(st_reg.speed);
			st_next.moving = 1'b1;
			st_next.halting = 1'b0;
			st_next.done = 1'b0;
		end
		if (wr_cmd && reg_wdata[CMD_SMOOTH_HALT_BIT] && !reg_wdata[CMD_STOP_BIT]
			&& st_reg.ctrl[CTRL_ACCEL_BIT] && st_reg.moving) begin
			st_next.moving = 1'b1;
			st_next.halting = 1'b1;
		end else if (wr_cmd && (reg_wdata[CMD_STOP_BIT] || reg_wdata[CMD_SMOOTH_HALT_BIT])) begin
			// Holding the running target at the shaft leaves no error to drive on.
			st_next.vel = '0;
			st_next.moving = 1'b0;
			st_next.halting = 1'b0;
			st_next.run_pos = st_reg.meas_pos;
		end

		// Regulator sequence, started by the period tick.
		case (st_reg.fsm)
			ST_IDLE: begin
				if (tick) begin
					st_next.fsm = ST_CALC;
				end
			end
			ST_CALC: begin
				st_next.err_prev = err;
				st_next.integ = integ_new;
				st_next.neg = u_sum[63];
				st_next.div_num = NUM_W'(u_abs) * NUM_W'(st_reg.unom);
				// The product is widened first; a bare 16-bit product would wrap to zero at 256 * 256.
				st_next.div_den = DEN_W'({32'(supply_level) * 32'(st_reg.encoder_counts_per_rev), {DEN_SH{1'b0}}});
				st_next.div_start = 1'b1;
				st_next.fsm = ST_DIV;
			end
			ST_DIV: begin
				if (div_done) begin
					st_next.fsm = ST_APPLY;
				end
			end
			ST_APPLY: begin
				// Only one of the two drive outputs is active at a time.
				if (st_reg.ctrl[CTRL_BLDC_BIT]) begin
					st_next.cur = duty;
					st_next.pwm = '0;
				end else begin
					st_next.pwm = duty;
					st_next.cur = '0;
				end
				st_next.fsm = ST_IDLE;
			end
			default: st_next.fsm = ST_IDLE;
		endcase

		// Read data stands in the cycle after the strobe only.
		st_next.rdata = '0;
		if (reg_rd) begin
			case (reg_addr)
				REG_CTRL: st_next.rdata = 32'(st_reg.ctrl);
				REG_KP: st_next.rdata = 32'(st_reg.kp);
				REG_KI: st_next.rdata = 32'(st_reg.ki);
				REG_KD: st_next.rdata = 32'(st_reg.kd);
				REG_UNOM: st_next.rdata = 32'(st_reg.unom);
				REG_IPS: st_next.rdata = 32'(st_reg.encoder_counts_per_rev);
				REG_SPEED: st_next.rdata = st_reg.speed;
				REG_DECEL: st_next.rdata = st_reg.decel;
				REG_TARGET: st_next.rdata = st_reg.target;
				REG_STATUS: st_next.rdata = {29'h0000_0000, st_reg.halting, st_reg.moving, st_reg.done};
				REG_MEAS: st_next.rdata = st_reg.meas_pos;
				REG_RUNPOS: st_next.rdata = st_reg.run_pos;
				REG_OUT: st_next.rdata = {st_reg.cur, st_reg.pwm};
				default: st_next.rdata = 32'h0000_0000;
			endcase
		end
	end

	// State register.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			st_reg <= '0;
			st_reg.ctrl <= CTRL_RST;
			st_reg.kp <= GAIN_RST;
			st_reg.ki <= GAIN_RST;
			st_reg.kd <= GAIN_RST;
			st_reg.unom <= UNOM_RST;
			st_reg.encoder_counts_per_rev <= IPS_RST;
			st_reg.speed <= SPEED_RST;
			st_reg.decel <= DECEL_RST;
			st_reg.fsm <= ST_IDLE;
		end else begin
			st_reg <= st_next;
		end
	end

	assign reg_rdata = st_reg.rdata;
	assign pwm_fill_factor = st_reg.pwm;
	assign current_cmd = st_reg.cur;
	assign move_done = st_reg.done;

	////////////////////////////////////////////////////////////////////////////////
	// Checks.
	property p_period;
		@(posedge core_clk) disable iff (srst) (st_reg.fsm == ST_IDLE && tick) |=> st_reg.fsm == ST_CALC ##1 st_reg.div_start;
	endproperty
	a_period: assert property (p_period) else $error("regulator step did not start on tick");

	property p_err;
		@(posedge core_clk) disable iff (srst) st_reg.fsm == ST_CALC |=> st_reg.err_prev == ERR_W'(clamp(64'($past(st_reg.run_pos)) - 64'($past(st_reg.meas_pos)), ERR_W));
	endproperty
	a_err: assert property (p_err) else $error("error is not target minus measured");

	property p_stop;
		@(posedge core_clk) disable iff (srst) (wr_cmd && reg_wdata[CMD_STOP_BIT]) |=> !st_reg.moving && st_reg.vel == 0 && st_reg.run_pos == $past(st_reg.meas_pos);
	endproperty
	a_stop: assert property (p_stop) else $error("immediate halt did not stop");

	property p_smooth_noaccel;
		@(posedge core_clk) disable iff (srst) (wr_cmd && reg_wdata[CMD_SMOOTH_HALT_BIT] && !st_reg.ctrl[CTRL_ACCEL_BIT]) |=> !st_reg.moving && st_reg.vel == 0;
	endproperty
	a_smooth_noaccel: assert property (p_smooth_noaccel) else $error("smooth halt ramped without accel mode");

	property p_smooth_ramp;
		@(posedge core_clk) disable iff (srst) (wr_cmd && reg_wdata[CMD_SMOOTH_HALT_BIT] && !reg_wdata[CMD_STOP_BIT] && st_reg.ctrl[CTRL_ACCEL_BIT] && st_reg.moving) |=> st_reg.halting && st_reg.moving;
	endproperty
	a_smooth_ramp: assert property (p_smooth_ramp) else $error("smooth halt did not ramp");

	property p_limit;
		@(posedge core_clk) disable iff (srst) (st_reg.ctrl[CTRL_HALT_LEFT_BIT] && st_reg.lim_l_sync[1] && st_reg.vel < 0 && !wr_cmd) |=> st_reg.vel == 0 && !st_reg.halting;
	endproperty
	a_limit: assert property (p_limit) else $error("left limit did not halt at once");

	property p_sat;
		@(posedge core_clk) disable iff (srst) st_reg.fsm == ST_APPLY && !st_reg.ctrl[CTRL_BLDC_BIT] |=> st_reg.pwm != 16'sh8000 && ($past(st_reg.neg) ? st_reg.pwm <= 0 : st_reg.pwm >= 0);
	endproperty
	a_sat: assert property (p_sat) else $error("duty out of range or wrong sign");

	property p_bldc;
		@(posedge core_clk) disable iff (srst) (st_reg.fsm == ST_APPLY && st_reg.ctrl[CTRL_BLDC_BIT]) |=> st_reg.pwm == 0 && st_reg.cur == $past(duty);
	endproperty
	a_bldc: assert property (p_bldc) else $error("BLDC output not on current command");

	property p_done;
		@(posedge core_clk) disable iff (srst) (!st_reg.moving && st_reg.meas_pos == st_reg.run_pos && !wr_cmd) |=> st_reg.done;
	endproperty
	a_done: assert property (p_done) else $error("move not flagged finished");
endmodule

// ===== dv/motor_encoder_model.sv
// Behavioural motor with a quadrature encoder on its shaft.
// Assumes one shaft step per STEP_DIV cycles while following the drive.
`timescale 1ns/100ps
module motor_encoder_model #(
	parameter int STEP_DIV = 500
) (
	// Clock.
	input wire logic core_clk,
	// Drive from the regulator.
	input wire logic [15:0] pwm_fill_factor,
	input wire logic [15:0] current_cmd,
	// Bench controls.
	input wire logic follow,
	input wire logic jog_up,
	input wire logic jog_dn,
	// Encoder pins.
	output logic enc_a,
	output logic enc_b
);
	logic [1:0] phase_reg = 2'h0;
	int div_cnt = 0;
	logic signed [15:0] drive;
	logic fwd;
	logic rev;

	// Only one drive output is live at a time, so the two can be merged.
	assign drive = $signed(pwm_fill_factor | current_cmd);
	assign fwd = jog_up || (follow && div_cnt == 0 && drive > 16'sh0000);
	assign rev = jog_dn || (follow && div_cnt == 0 && drive < 16'sh0000);

	// The divider stands for inertia, so even full drive takes time to move the shaft.
	always_ff @(posedge core_clk) begin
		div_cnt <= (div_cnt + 1) % STEP_DIV;
		if (fwd) begin
			phase_reg <= phase_reg + 2'h1;
		end else if (rev) begin
			phase_reg <= phase_reg - 2'h1;
		end
	end

	// Gray order 00, 01, 11, 10 counts upward in the regulator.
	assign enc_a = phase_reg[1];
	assign enc_b = phase_reg[1] ^ phase_reg[0];
endmodule

// ===== dv/pid_position_regulator_tb_top.sv
// Self-checking bench of the position regulator.
// Assumes the encoder model stands in for the motor and supply is set by the bench.
`timescale 1ns/100ps
module pid_position_regulator_tb_top;
	import pid_position_pkg::*;
	logic core_clk = 1'b0;
	logic srst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic [15:0] supply_level = 16'h0100;
	logic enc_a;
	logic enc_b;
	logic limit_left = 1'b0;
	logic limit_right = 1'b0;
	logic [15:0] pwm_fill_factor;
	logic [15:0] current_cmd;
	logic move_done;
	logic follow = 1'b0;
	logic jog_dn = 1'b0;
	logic [31:0] rv;
	int err_total = 0;
	int comparisons = 0;

	// Clock generator.
	always #25 core_clk = ~core_clk;

	pid_position_regulator uut (.core_clk(core_clk), .srst(srst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.supply_level(supply_level), .enc_a(enc_a), .enc_b(enc_b), .limit_left(limit_left),
		.limit_right(limit_right), .pwm_fill_factor(pwm_fill_factor), .current_cmd(current_cmd),
		.move_done(move_done));
	motor_encoder_model #(.STEP_DIV(500)) motor (.core_clk(core_clk),
		.pwm_fill_factor(pwm_fill_factor), .current_cmd(current_cmd), .follow(follow),
		.jog_up(1'b0), .jog_dn(jog_dn), .enc_a(enc_a), .enc_b(enc_b));

	////////////////////////////////////////////////////////////////////////
	// Shared tasks.
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe, so sample mid-cycle there.
	task automatic rd(input logic [7:0] a);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(negedge core_clk);
		rv = reg_rdata;
	endtask
	task automatic periods(input int n);
		repeat (n * CTRL_PERIOD_CYC + 100) @(posedge core_clk);
		@(negedge core_clk);
	endtask
	task automatic final_report;
		$display("comparisons %0d, mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// Scenarios.
	task automatic t_reset;
		rd(REG_UNOM);
		chk(rv, 32'h0000_0100);
		rd(REG_IPS);
		chk(rv, 32'h0000_0100);
		rd(REG_DECEL);
		chk(rv, 32'h0000_0001);
		rd(REG_KP);
		chk(rv, 32'h0000_0000);
		rd(REG_STATUS);
		chk(rv, 32'h0000_0001);
		wr(8'h3C, 32'hFFFF_FFFF);
		rd(8'h3C);
		chk(rv, 32'h0000_0000);
		rd(REG_CMD);
		chk(rv, 32'h0000_0000);
		$display("test reset finished");
	endtask
	// Shaft five counts behind the running target, so the error is +5.
	task automatic t_gain;
		repeat (5) begin
			@(posedge core_clk);
			jog_dn <= 1'b1;
			@(posedge core_clk);
			jog_dn <= 1'b0;
		end
		wr(REG_KP, 32'h0000_0064);
		periods(2);
		chk({16'h0, pwm_fill_factor}, 32'h0000_00FA);
		wr(REG_KP, 32'h0000_FFFF);
		periods(2);
		chk({16'h0, pwm_fill_factor}, 32'h0000_7FFF);
		wr(REG_KP, 32'h0000_0064);
		supply_level <= 16'h0200;
		periods(2);
		chk({16'h0, pwm_fill_factor}, 32'h0000_007D);
		wr(REG_UNOM, 32'h0000_0200);
		periods(2);
		chk({16'h0, pwm_fill_factor}, 32'h0000_00FA);
		wr(REG_CTRL, 32'h0000_0001);
		periods(2);
		chk({pwm_fill_factor, current_cmd}, 32'h0000_00FA);
		wr(REG_CTRL, 32'h0000_0000);
		wr(REG_UNOM, 32'h0000_0100);
		supply_level <= 16'h0100;
		$display("test gain finished");
	endtask
	// Closed loop: the motor follows the drive until it meets the running target.
	task automatic t_follow;
		int n;
		wr(REG_SPEED, 32'h0000_0014);
		wr(REG_TARGET, 32'h0000_0014);
		wr(REG_KP, 32'h0000_FFFF);
		follow <= 1'b1;
		wr(REG_CMD, 32'h0000_0001);
		rd(REG_STATUS);
		chk(rv, 32'h0000_0002);
		for (n = 0; n < 40000 && move_done !== 1'b1; n++) @(posedge core_clk);
		chk({31'h0, move_done}, 32'h0000_0001);
		follow <= 1'b0;
		rd(REG_RUNPOS);
		chk(rv, 32'h0000_0014);
		$display("test follow finished");
	endtask
	task automatic t_halt;
		logic [31:0] run;
		wr(REG_TARGET, 32'h0000_03E8);
		wr(REG_CMD, 32'h0000_0001);
		periods(1);
		wr(REG_CMD, 32'h0000_0002);
		rd(REG_STATUS);
		chk({30'h0, rv[2:1]}, 32'h0000_0000);
		rd(REG_RUNPOS);
		run = rv;
		rd(REG_MEAS);
		chk(run, rv);
		$display("test halt finished");
	endtask
	// Ramp from 10 by 4 per period: 6, 2, then zero on the third period.
	task automatic t_smooth;
		wr(REG_CTRL, 32'h0000_0002);
		wr(REG_DECEL, 32'h0000_0004);
		wr(REG_SPEED, 32'h0000_000A);
		wr(REG_CMD, 32'h0000_0001);
		wr(REG_CMD, 32'h0000_0004);
		rd(REG_STATUS);
		chk({30'h0, rv[2:1]}, 32'h0000_0003);
		repeat (CTRL_PERIOD_CYC) @(posedge core_clk);
		rd(REG_STATUS);
		chk({31'h0, rv[1]}, 32'h0000_0001);
		repeat (3 * CTRL_PERIOD_CYC) @(posedge core_clk);
		rd(REG_STATUS);
		chk({31'h0, rv[1]}, 32'h0000_0000);
		wr(REG_CTRL, 32'h0000_0000);
		wr(REG_CMD, 32'h0000_0001);
		wr(REG_CMD, 32'h0000_0004);
		rd(REG_STATUS);
		chk({30'h0, rv[2:1]}, 32'h0000_0000);
		$display("test smooth finished");
	endtask
	task automatic t_limit;
		wr(REG_CTRL, 32'h0000_0008);
		wr(REG_CMD, 32'h0000_0001);
		limit_right <= 1'b1;
		repeat (6) @(posedge core_clk);
		rd(REG_STATUS);
		chk({31'h0, rv[1]}, 32'h0000_0000);
		limit_right <= 1'b0;
		// Left side: a move toward a far negative target is cut by the left switch.
		wr(REG_CTRL, 32'h0000_0004);
		wr(REG_TARGET, 32'hFFFF_FC18);
		wr(REG_CMD, 32'h0000_0001);
		limit_left <= 1'b1;
		repeat (6) @(posedge core_clk);
		rd(REG_STATUS);
		chk({31'h0, rv[1]}, 32'h0000_0000);
		limit_left <= 1'b0;
		wr(REG_CTRL, 32'h0000_0000);
		$display("test limit finished");
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial begin
		repeat (4) @(posedge core_clk);
		srst <= 1'b0;
		t_reset();
		t_gain();
		t_follow();
		t_halt();
		t_smooth();
		t_limit();
		final_report();
	end

	// Watchdog: the scenarios take about 43000 cycles.
	initial begin
		repeat (100000) @(posedge core_clk);
		err_total++;
		final_report();
	end
endmodule
